//--- design/seeprm_pkg.sv
// Constants and carrier types for the serial memory front end.
// Assumes a 100 MHz system clock; the serial link is sampled, not clocked.
package seeprm_pkg;
	localparam int SEEPRM_DEPTH = 2048;
	localparam int SEEPRM_AW = 11;
	localparam logic [7:0] SEEPRM_OP_READ = 8'h03;
	localparam logic [7:0] SEEPRM_OP_WRITE = 8'h02;
	localparam logic [7:0] SEEPRM_OP_SET_WRITE_LATCH_CMD = 8'h06;
	localparam logic [7:0] SEEPRM_OP_WRDI = 8'h04;
	localparam logic [7:0] SEEPRM_OP_RDSR = 8'h05;
	localparam int SEEPRM_CLK_MHZ = 100;
	localparam int SEEPRM_TWC_MS = 5;
	localparam int SEEPRM_TWC_CYC = SEEPRM_TWC_MS * 1000 * 1000
		* SEEPRM_CLK_MHZ / 1000;
	localparam int SEEPRM_FIFO_DEPTH = 16;
	localparam int SEEPRM_CNT_W = 23;
	localparam logic [2:0] SEEPRM_SYNC_RST = 3'h7;

	typedef enum logic [2:0] {
		SEEPRM_ST_CMD = 3'h0,
		SEEPRM_ST_ADDR = 3'h1,
		SEEPRM_ST_WDATA = 3'h3,
		SEEPRM_ST_RDATA = 3'h2,
		SEEPRM_ST_IDLE = 3'h6
	} seeprm_state_t;

	typedef struct packed {
		logic [SEEPRM_AW-1:0] addr;
		logic [7:0] data;
	} seeprm_wr_t;
endpackage : seeprm_pkg

//--- design/seeprm_fifo.sv
// Small synchronous FIFO holding pending array writes.
// Assumes one clock; pop side may stall so the FIFO can fill.
`timescale 1ns/100ps
`default_nettype none
module seeprm_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Fill side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_q;
	logic [PW:0] rd_q;
	wire full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
	wire empty = (wr_q == rd_q);
	wire push = in_valid && !full;
	wire pop = out_ready && !empty;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_q[PW-1:0]];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q[PW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (PW+1)'(push);
			rd_q <= rd_q + (PW+1)'(pop);
		end
	end
	a_fifo_no_over: assert property (@(posedge clk) disable iff (!nrst)
		full |-> ##1 (wr_q == $past(wr_q)))
		else $error("FIFO pushed while full.");
endmodule : seeprm_fifo
`default_nettype wire

//--- design/seeprm_core.sv
// Serial front end of a 2048-byte memory with pause and timed write cycle.
// Assumes select, serial clock, data in and pause come from pins; the serial
// clock is far slower than clk and is only sampled here.
`timescale 1ns/100ps
`default_nettype none
module seeprm_core
	import seeprm_pkg::*;
#(
	parameter int TWC_CYCLES = seeprm_pkg::SEEPRM_TWC_CYC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Serial link pins.
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic pause_n,
	output logic sdo,
	output logic sdo_oe,
	// Write cycle status.
	output logic write_busy_flag
);
	import seeprm_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic sclk3_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= 4'h9;
			s2_q <= 4'h9;
			sclk3_q <= 1'h0;
		end else begin
			s1_q <= {pause_n, sdi, sclk, sel_n};
			s2_q <= s1_q;
			sclk3_q <= s2_q[1];
		end
	end
	wire sel_s = s2_q[0];
	wire sclk_s = s2_q[1];
	wire sdi_s = s2_q[2];
	wire pause_s = !s2_q[3];
	logic sel_q;
	wire active = !sel_s && !pause_s;
	wire rise = active && sclk_s && !sclk3_q;
	wire fall = active && !sclk_s && sclk3_q;
	wire sel_rise = sel_s && !sel_q;

	// ------------------------------------------------------------
	// Transfer state
	// ------------------------------------------------------------
	logic [7:0] mem [SEEPRM_DEPTH];
	seeprm_state_t st_q;
	logic [7:0] ir_q;
	logic [2:0] bit_q;
	logic [4:0] acnt_q;
	logic [15:0] addr_q;
	logic [7:0] sh_q;
	logic [7:0] out_q;
	logic wel_q;
	logic wel_pend_q;
	logic wr_pend_q;
	logic byte_done_q;
	logic [SEEPRM_CNT_W-1:0] twc_q;
	logic sdo_q;
	logic oe_q;
	logic busy_q;
	logic purge_q;

	wire [7:0] ir_d = {ir_q[6:0], sdi_s};
	wire [15:0] ad_d = {addr_q[14:0], sdi_s};
	wire [7:0] sh_d = {sh_q[6:0], sdi_s};
	wire [SEEPRM_AW-1:0] aptr = addr_q[SEEPRM_AW-1:0];
	wire [SEEPRM_AW-1:0] anext = aptr + 11'h001;
	wire cmd_last = (st_q == SEEPRM_ST_CMD) && (bit_q == 3'h7);
	wire addr_last = (st_q == SEEPRM_ST_ADDR) && (acnt_q == 5'h0F);
	wire data_last = (st_q == SEEPRM_ST_WDATA) && (bit_q == 3'h7);
	wire rd_op = (ir_d == SEEPRM_OP_READ) && !busy_q;
	wire wr_op = (ir_d == SEEPRM_OP_WRITE) && wel_q && !busy_q;
	wire [7:0] status = {6'h00, wel_q, busy_q};

	seeprm_wr_t fin;
	seeprm_wr_t fout;
	logic f_in_valid;
	logic f_in_ready;
	logic f_out_valid;
	// Queued bytes land in the first cycles of the timed write, so the
	// write time must be longer than the queue is deep.
	wire drain = (busy_q || purge_q) && f_out_valid;
	wire twc_end = busy_q && (twc_q == SEEPRM_CNT_W'(TWC_CYCLES - 1));
	assign fin.addr = aptr;
	assign fin.data = sh_d;
	assign f_in_valid = rise && data_last && wr_pend_q;

	seeprm_fifo #(
		.WIDTH($bits(seeprm_wr_t)),
		.DEPTH(SEEPRM_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(fin),
		.out_valid(f_out_valid),
		.out_ready(drain),
		.out_data(fout)
	);

	always_ff @(posedge clk) begin
		if (drain && busy_q) begin
			mem[fout.addr] <= fout.data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sel_q <= 1'h1;
			st_q <= SEEPRM_ST_CMD;
			ir_q <= 8'h00;
			bit_q <= 3'h0;
			acnt_q <= 5'h00;
			addr_q <= 16'h0000;
			sh_q <= 8'h00;
			out_q <= 8'h00;
			wel_q <= 1'h0;
			wel_pend_q <= 1'h0;
			wr_pend_q <= 1'h0;
			byte_done_q <= 1'h0;
		end else begin
			sel_q <= sel_s;
			if (sel_s) begin
				// Select high restarts framing and commits latch set and write clear; WRDI clears the latch at once.
				st_q <= SEEPRM_ST_CMD;
				bit_q <= 3'h0;
				acnt_q <= 5'h00;
				if (sel_rise && wel_pend_q) begin
					wel_q <= 1'h1;
				end
				if (sel_rise && wr_pend_q && byte_done_q) begin
					wel_q <= 1'h0;
				end
				wel_pend_q <= 1'h0;
				wr_pend_q <= 1'h0;
				byte_done_q <= 1'h0;
			end else if (rise) begin
				bit_q <= bit_q + 3'h1;
				case (st_q)
					SEEPRM_ST_CMD: begin
						ir_q <= ir_d;
						if (cmd_last) begin
							acnt_q <= 5'h00;
							if (rd_op || wr_op) begin
								st_q <= SEEPRM_ST_ADDR;
							end else if (ir_d == SEEPRM_OP_RDSR) begin
								out_q <= status;
								st_q <= SEEPRM_ST_RDATA;
							end else begin
								st_q <= SEEPRM_ST_IDLE;
							end
							wel_pend_q <= (ir_d == SEEPRM_OP_SET_WRITE_LATCH_CMD);
							if (ir_d == SEEPRM_OP_WRDI) begin
								wel_q <= 1'h0;
							end
							wr_pend_q <= wr_op;
						end
					end
					SEEPRM_ST_ADDR: begin
						addr_q <= ad_d;
						acnt_q <= acnt_q + 5'h01;
						if (addr_last) begin
							bit_q <= 3'h0;
							if (wr_pend_q) begin
								st_q <= SEEPRM_ST_WDATA;
							end else begin
								out_q <= mem[ad_d[SEEPRM_AW-1:0]];
								st_q <= SEEPRM_ST_RDATA;
							end
						end
					end
					SEEPRM_ST_WDATA: begin
						sh_q <= sh_d;
						byte_done_q <= data_last;
						if (data_last) begin
							addr_q <= {5'h00, anext};
						end
					end
					SEEPRM_ST_RDATA: begin
						if (bit_q == 3'h7) begin
							if (ir_q == SEEPRM_OP_RDSR) begin
								out_q <= status;
							end else begin
								addr_q <= {5'h00, anext};
								out_q <= mem[anext];
							end
						end
					end
					default: begin
						st_q <= SEEPRM_ST_IDLE;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Output shifting and write timer
	// ------------------------------------------------------------
	wire rd_phase = (st_q == SEEPRM_ST_RDATA) && !sel_s && !pause_s;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sdo_q <= 1'h0;
			oe_q <= 1'h0;
			busy_q <= 1'h0;
			purge_q <= 1'h0;
			twc_q <= '0;
		end else begin
			oe_q <= rd_phase;
			if (fall && st_q == SEEPRM_ST_RDATA) begin
				sdo_q <= out_q[3'h7 - bit_q];
			end
			// A frame that ends off a byte boundary writes nothing.
			if (sel_rise && wr_pend_q && !byte_done_q) begin
				purge_q <= 1'h1;
			end else if (!f_out_valid) begin
				purge_q <= 1'h0;
			end
			// One timed cycle covers the first 16 bytes of the frame; later bytes are dropped.
			if (sel_rise && wr_pend_q && byte_done_q) begin
				busy_q <= 1'h1;
				twc_q <= '0;
			end else if (twc_end) begin
				busy_q <= 1'h0;
				twc_q <= '0;
			end else if (busy_q) begin
				twc_q <= twc_q + SEEPRM_CNT_W'(1);
			end
		end
	end
	assign sdo = sdo_q;
	assign sdo_oe = oe_q;
	assign write_busy_flag = busy_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_oe_when_sel: assert property (
		@(posedge clk) disable iff (!nrst) sel_s |=> !sdo_oe)
		else $error("Output driven while deselected.");
	a_pause_freeze: assert property (
		@(posedge clk) disable iff (!nrst)
		pause_s && !sel_s |=> $stable(bit_q) && $stable(st_q))
		else $error("State moved while paused.");
	a_busy_start: assert property (
		@(posedge clk) disable iff (!nrst)
		sel_rise && wr_pend_q && byte_done_q |=> write_busy_flag)
		else $error("Write cycle did not start.");
	a_busy_len: assert property (
		@(posedge clk) disable iff (!nrst)
		busy_q |-> twc_q < SEEPRM_CNT_W'(TWC_CYCLES))
		else $error("Write cycle overran.");
	a_wel_needed: assert property (
		@(posedge clk) disable iff (!nrst)
		rise && cmd_last && ir_d == SEEPRM_OP_WRITE && !wel_q
		|=> !wr_pend_q && st_q == SEEPRM_ST_IDLE)
		else $error("Write accepted without latch.");
	a_first_bit: assert property (
		@(posedge clk) disable iff (!nrst)
		$rose(!sel_s) |-> bit_q == 3'h0 && st_q == SEEPRM_ST_CMD)
		else $error("Frame did not restart.");
	a_ir_shift: assert property (
		@(posedge clk) disable iff (!nrst)
		rise && st_q == SEEPRM_ST_CMD |=> ir_q[0] == $past(sdi_s))
		else $error("Instruction bit lost.");
	a_sdo_fall: assert property (
		@(posedge clk) disable iff (!nrst)
		!$stable(sdo_q) |-> $past(fall))
		else $error("Output changed off falling edge.");
	c_read: cover property (@(posedge clk) rise && addr_last && !wr_pend_q);
	c_write: cover property (@(posedge clk) $rose(write_busy_flag));
	c_pause: cover property (@(posedge clk) pause_s && !sel_s);
endmodule : seeprm_core
`default_nettype wire

//--- tb/seeprm_master.sv
// Master model that drives the serial link pins of the memory front end.
// Assumes the bench calls its tasks; one link clock period is 8 clk cycles.
`timescale 1ns/100ps
`default_nettype none
module seeprm_master (
	// Clock.
	input wire logic clk,
	// Link pins.
	output logic sel_n,
	output logic sclk,
	output logic sdi,
	output logic pause_n,
	input wire logic sdo,
	input wire logic sdo_oe
);
	wire logic pin = sdo_oe ? sdo : 1'bz;
	logic oe_in_pause;

	initial begin
		sel_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		pause_n = 1'b1;
		oe_in_pause = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// The link clock stands low outside frames.
	task automatic open;
		sel_n = 1'b0;
		tick(4);
	endtask : open

	task automatic close;
		tick(4);
		sel_n = 1'b1;
		sdi = ~sdi;
		tick(8);
	endtask : close

	// A pause before bit pz toggles clock and data, which must be ignored.
	task automatic xfer(input logic [7:0] tx, input int pz,
		output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			if (i == pz) begin
				// Pause edges stand apart from link clock edges.
				tick(4);
				pause_n = 1'b0;
				for (int k = 0; k < 3; k++) begin
					tick(4);
					sclk = 1'b1;
					sdi = ~sdi;
					tick(4);
					sclk = 1'b0;
				end
				tick(4);
				oe_in_pause = sdo_oe;
				pause_n = 1'b1;
				tick(4);
			end
			sdi = tx[i];
			tick(4);
			rx[i] = pin;
			sclk = 1'b1;
			tick(4);
			sclk = 1'b0;
		end
	endtask : xfer
endmodule : seeprm_master
`default_nettype wire

//--- tb/seeprm_core_bench.sv
// Self-checking bench for the serial memory front end.
// Assumes the master model on the link and a shortened write cycle.
`timescale 1ns/100ps
`default_nettype none
module seeprm_core_bench;
	import seeprm_pkg::*;
	localparam int TWC = 200;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	wire logic sel_n, sclk, sdi, pause_n, sdo, sdo_oe, busy;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	int busy_len = 0;
	logic [7:0] r;

	always #5 clk = ~clk;

	seeprm_core #(.TWC_CYCLES(TWC)) seeprm_core_inst (.clk(clk),
		.nrst(nrst), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
		.pause_n(pause_n), .sdo(sdo), .sdo_oe(sdo_oe),
		.write_busy_flag(busy));
	seeprm_master seeprm_master_inst (.clk(clk), .sel_n(sel_n),
		.sclk(sclk), .sdi(sdi), .pause_n(pause_n), .sdo(sdo),
		.sdo_oe(sdo_oe));

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	always @(posedge clk) begin
		cycles++;
		busy_len += (busy === 1'b1);
		if (cycles == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// Link helpers.
	// ------------------------------------------------------------
	task automatic tk(input int n);
		seeprm_master_inst.tick(n);
	endtask : tk

	task automatic op1(input logic [7:0] b);
		seeprm_master_inst.xfer(b, -1, r);
	endtask : op1

	task automatic opn;
		seeprm_master_inst.open();
	endtask : opn

	task automatic cls;
		seeprm_master_inst.close();
	endtask : cls

	task automatic status;
		opn();
		op1(SEEPRM_OP_RDSR);
		op1(8'h00);
		cls();
	endtask : status

	// ------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------
	task automatic t_idle;
		check("sdo_oe idle", {7'h00, sdo_oe}, 8'h00);
		check("busy idle", {7'h00, busy}, 8'h00);
		$display("test idle done");
	endtask : t_idle

	// Two bytes from the top address wrap to zero in one timed cycle.
	task automatic t_write;
		int n;
		opn();
		op1(SEEPRM_OP_SET_WRITE_LATCH_CMD);
		cls();
		busy_len = 0;
		opn();
		op1(SEEPRM_OP_WRITE);
		op1(8'hFF);
		op1(8'hFF);
		op1(8'h5A);
		op1(8'hA5);
		cls();
		check("busy after write", {7'h00, busy}, 8'h01);
		status();
		check("status in write", r, 8'h01);
		n = 0;
		while (busy !== 1'b0 && n < 1000) begin
			tk(1);
			n++;
		end
		check("busy cycles", {7'h00, busy_len == TWC}, 8'h01);
		status();
		check("status after write", r, 8'h00);
		$display("test write done");
	endtask : t_write

	// A write without the latch and a write with no data change nothing.
	task automatic t_refuse;
		int n;
		opn();
		op1(SEEPRM_OP_WRITE);
		op1(8'hFF);
		op1(8'hFF);
		op1(8'h11);
		cls();
		opn();
		op1(SEEPRM_OP_SET_WRITE_LATCH_CMD);
		cls();
		opn();
		op1(SEEPRM_OP_WRITE);
		op1(8'h00);
		op1(8'h00);
		cls();
		n = 0;
		repeat (20) begin
			tk(1);
			n += (busy !== 1'b0);
		end
		check("busy refused", n[7:0], 8'h00);
		$display("test refuse done");
	endtask : t_refuse

	// Pauses fall in the address and in the data; nothing may be lost.
	task automatic t_read;
		opn();
		op1(SEEPRM_OP_READ);
		seeprm_master_inst.xfer(8'hFF, 5, r);
		op1(8'hFF);
		seeprm_master_inst.xfer(8'h00, 3, r);
		check("data at top", r, 8'h5A);
		check("oe in pause", {7'h00, seeprm_master_inst.oe_in_pause}, 8'h00);
		op1(8'h00);
		check("data wrapped", r, 8'hA5);
		cls();
		check("oe after frame", {7'h00, sdo_oe}, 8'h00);
		$display("test read done");
	endtask : t_read

	initial begin
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
		tk(4);
		t_idle();
		t_write();
		t_refuse();
		t_read();
		end_of_test();
	end
endmodule : seeprm_core_bench
`default_nettype wire
